/* File: core/amo_cfg.svh */
// constants of the angle output mapping block
`ifndef AMO_CFG_SVH
`define AMO_CFG_SVH

// ---------------------------------------------------------------
// register addresses
// ---------------------------------------------------------------
`define AMO_ADDR_ZERO   4'h7
`define AMO_ADDR_MLOW   4'h9
`define AMO_ADDR_CLO    4'ha
`define AMO_ADDR_CHI    4'hb
`define AMO_ADDR_SWMH   4'he
`define AMO_ADDR_CUST   4'hf

// ---------------------------------------------------------------
// field positions
// ---------------------------------------------------------------
`define AMO_MLOW_MSB    15
`define AMO_MLOW_LSB    3
`define AMO_CLAMP_MSB   12
`define AMO_THR_MSB     15
`define AMO_THR_LSB     6
`define AMO_MHIGH_MSB   5
`define AMO_SLOPE_BIT   8
`define AMO_REL_LSB     3
`define AMO_MULT_FRAC   14

// ---------------------------------------------------------------
// reset values
// ---------------------------------------------------------------
`define AMO_RST_ZERO    16'h0000
`define AMO_RST_MLOW    16'h2000
`define AMO_RST_CLO     16'h0100
`define AMO_RST_CHI     16'h12ff
`define AMO_RST_SWMH    16'hffc1
`define AMO_RST_CUST    16'h0c00

`endif

/* File: core/amo_pkg.sv */
// types of the angle output mapping block
`include "amo_cfg.svh"

package amo_pkg;

  // register access request
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [3:0]  addr;
    logic [15:0] wdata;
  } amo_reg_req_type;

  // decoded mapping parameters
  typedef struct packed {
    logic [15:0] zero;
    logic [18:0] mult;
    logic [12:0] lower_clamp_level;
    logic [12:0] upper_clamp_level;
    logic [9:0]  thr;
    logic        falling;
  } amo_map_type;

endpackage : amo_pkg

/* File: core/amo_scale.sv */
// scaling of the offset angle by the range multiplier
`timescale 1ns/1ps
`include "amo_cfg.svh"

module amo_scale
  import amo_pkg::*;
(
  input  wire logic [15:0] rel,
  input  wire logic [18:0] mult,
  output logic      [17:0] delta
);

  logic [31:0] prod;

  // angle fraction of 180 deg to 13-bit dac span, times multiplier
  always_comb
  begin
    prod  = {19'h00000, rel[15:`AMO_REL_LSB]} * {13'h0000, mult};
    delta = prod[`AMO_MULT_FRAC+17:`AMO_MULT_FRAC];
  end

endmodule : amo_scale

/* File: core/amo_angle_map.sv */
// angle to output code mapping with its parameter registers
//
// Functional notes
// - zero offset is unsigned fraction of 180 deg, lsb two to minus sixteen
// - multiplier low part from word 9h bits 15..3, bits 2..0 ignored
// - undefined bits are written zero; reads there may return anything
// - multiplier high part from word Eh bits 5..0, weights 2^4..2^-1
// - clamp switch angle is 10-bit fraction in word Eh bits 15..6
// - rising slope and angle beyond switch angle forces lower clamp
// - slope bit zero gives rising transfer, one gives falling
`timescale 1ns/1ps
`include "amo_cfg.svh"

module amo_angle_map
  import amo_pkg::*;
(
  input  wire logic        CLK,
  input  wire logic        SYS_RST,
  input  wire logic        REG_WR,
  input  wire logic        REG_RD,
  input  wire logic [3:0]  REG_ADDR,
  input  wire logic [15:0] REG_WDATA,
  output logic      [15:0] REG_RDATA,
  output logic             REG_RVALID,
  input  wire logic        ANGLE_VALID,
  input  wire logic [15:0] ANGLE,
  output logic      [12:0] OUT_CODE,
  output logic             OUT_VALID,
  output logic             OUT_FORCED
);

  // ---------------------------------------------------------------
  // register file
  // ---------------------------------------------------------------
  amo_reg_req_type req;
  amo_map_type     map;
  logic [15:0]     zero_word;
  logic [15:0]     mlow_word;
  logic [15:0]     clo_word;
  logic [15:0]     chi_word;
  logic [15:0]     swmh_word;
  logic [15:0]     cust_word;
  logic [15:0]     next_zero_word;
  logic [15:0]     next_mlow_word;
  logic [15:0]     next_clo_word;
  logic [15:0]     next_chi_word;
  logic [15:0]     next_swmh_word;
  logic [15:0]     next_cust_word;
  logic [15:0]     next_rdata;
  logic            next_rvalid;

  assign req = '{wr: REG_WR, rd: REG_RD, addr: REG_ADDR, wdata: REG_WDATA};

  // write decode and read mux; a read in a write cycle returns the old word
  // words stored whole
  always_comb
  begin
    next_zero_word = zero_word;
    next_mlow_word = mlow_word;
    next_clo_word  = clo_word;
    next_chi_word  = chi_word;
    next_swmh_word = swmh_word;
    next_cust_word = cust_word;
    next_rvalid    = req.rd;
    next_rdata     = REG_RDATA;
    if (req.wr)
    begin
      case (req.addr)
        `AMO_ADDR_ZERO: next_zero_word = req.wdata;
        `AMO_ADDR_MLOW: next_mlow_word = req.wdata;
        `AMO_ADDR_CLO:  next_clo_word  = req.wdata;
        `AMO_ADDR_CHI:  next_chi_word  = req.wdata;
        `AMO_ADDR_SWMH: next_swmh_word = req.wdata;
        `AMO_ADDR_CUST: next_cust_word = req.wdata;
        default:        next_zero_word = zero_word;
      endcase
    end
    if (req.rd)
    begin
      case (req.addr)
        `AMO_ADDR_ZERO: next_rdata = zero_word;
        `AMO_ADDR_MLOW: next_rdata = mlow_word;
        `AMO_ADDR_CLO:  next_rdata = clo_word;
        `AMO_ADDR_CHI:  next_rdata = chi_word;
        `AMO_ADDR_SWMH: next_rdata = swmh_word;
        `AMO_ADDR_CUST: next_rdata = cust_word;
        default:        next_rdata = 16'h0000;
      endcase
    end
  end

  // register the parameter words
  always_ff @(posedge CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      zero_word  <= `AMO_RST_ZERO;
      mlow_word  <= `AMO_RST_MLOW;
      clo_word   <= `AMO_RST_CLO;
      chi_word   <= `AMO_RST_CHI;
      swmh_word  <= `AMO_RST_SWMH;
      cust_word  <= `AMO_RST_CUST;
      REG_RDATA  <= 16'h0000;
      REG_RVALID <= 1'b0;
    end
    else
    begin
      zero_word  <= next_zero_word;
      mlow_word  <= next_mlow_word;
      clo_word   <= next_clo_word;
      chi_word   <= next_chi_word;
      swmh_word  <= next_swmh_word;
      cust_word  <= next_cust_word;
      REG_RDATA  <= next_rdata;
      REG_RVALID <= next_rvalid;
    end
  end

  // ---------------------------------------------------------------
  // field decode
  // ---------------------------------------------------------------
  // zero offset, multiplier, clamp levels, switch angle and slope bit from the words
  always_comb
  begin
    map.zero     = zero_word;
    map.mult     = {swmh_word[`AMO_MHIGH_MSB:0], mlow_word[`AMO_MLOW_MSB:`AMO_MLOW_LSB]};
    map.lower_clamp_level = clo_word[`AMO_CLAMP_MSB:0];
    map.upper_clamp_level = chi_word[`AMO_CLAMP_MSB:0];
    map.thr      = swmh_word[`AMO_THR_MSB:`AMO_THR_LSB];
    map.falling  = cust_word[`AMO_SLOPE_BIT];
  end

  // ---------------------------------------------------------------
  // transfer function
  // ---------------------------------------------------------------
  logic [15:0] rel;
  logic [17:0] delta;
  logic [18:0] rise_sum;
  logic [12:0] span;
  logic        beyond;
  logic [12:0] next_code;
  logic        next_forced;

  // angle relative to mechanical zero, wraps over 180 deg
  assign rel = ANGLE - map.zero;

  amo_scale u_scale
  (
    .rel   (rel),
    .mult  (map.mult),
    .delta (delta)
  );

  // clamped output code and switch to lower clamp
  always_comb
  begin
    rise_sum    = {6'h00, map.lower_clamp_level} + {1'b0, delta};
    span        = map.upper_clamp_level - map.lower_clamp_level;
    beyond      = rel[15:`AMO_THR_LSB] > map.thr;
    next_forced = 1'b0;
    next_code   = map.lower_clamp_level;
    if (map.falling)
    begin
      if (delta > {5'h00, span})
        next_code = map.lower_clamp_level;
      else
        next_code = map.upper_clamp_level - delta[12:0];
    end
    else if (beyond)
    begin
      next_code   = map.lower_clamp_level;
      next_forced = 1'b1;
    end
    else if (rise_sum > {6'h00, map.upper_clamp_level})
      next_code = map.upper_clamp_level;
    else
      next_code = rise_sum[12:0];
  end

  // output registers, updated on each valid angle
  always_ff @(posedge CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      OUT_CODE   <= 13'h0000;
      OUT_VALID  <= 1'b0;
      OUT_FORCED <= 1'b0;
    end
    else
    begin
      OUT_VALID <= ANGLE_VALID;
      if (ANGLE_VALID)
      begin
        OUT_CODE   <= next_code;
        OUT_FORCED <= next_forced;
      end
    end
  end

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  property p_zero_maps_low;
    @(posedge CLK) disable iff (SYS_RST)
    ANGLE_VALID && (ANGLE == zero_word) && !map.falling && !REG_WR
    |=> OUT_CODE == $past(clo_word[`AMO_CLAMP_MSB:0]);
  endproperty
  a_zero_maps_low: assert property (p_zero_maps_low)
    else $error("zero angle did not map to lower clamp");

  property p_mlow_field;
    @(posedge CLK) disable iff (SYS_RST)
    REG_WR && (REG_ADDR == `AMO_ADDR_MLOW)
    |=> map.mult[12:0] == $past(REG_WDATA[15:3]);
  endproperty
  a_mlow_field: assert property (p_mlow_field)
    else $error("multiplier low part not taken from bits 15..3");

  property p_readback;
    @(posedge CLK) disable iff (SYS_RST)
    REG_WR && (REG_ADDR == `AMO_ADDR_ZERO) ##1 REG_RD && !REG_WR && (REG_ADDR == `AMO_ADDR_ZERO)
    |=> REG_RVALID && (REG_RDATA == $past(REG_WDATA, 2));
  endproperty
  a_readback: assert property (p_readback)
    else $error("written word not read back");

  property p_mhigh_field;
    @(posedge CLK) disable iff (SYS_RST)
    REG_WR && (REG_ADDR == `AMO_ADDR_SWMH)
    |=> map.mult[18:13] == $past(REG_WDATA[5:0]);
  endproperty
  a_mhigh_field: assert property (p_mhigh_field)
    else $error("multiplier high part not taken from bits 5..0");

  property p_thr_field;
    @(posedge CLK) disable iff (SYS_RST)
    REG_WR && (REG_ADDR == `AMO_ADDR_SWMH)
    |=> map.thr == $past(REG_WDATA[`AMO_THR_MSB:`AMO_THR_LSB]);
  endproperty
  a_thr_field: assert property (p_thr_field)
    else $error("switch angle not taken from bits 15..6");

  property p_force_low;
    @(posedge CLK) disable iff (SYS_RST)
    ANGLE_VALID && !map.falling && (rel[15:6] > map.thr)
    |=> OUT_FORCED && (OUT_CODE == $past(map.lower_clamp_level));
  endproperty
  a_force_low: assert property (p_force_low)
    else $error("output not forced to lower clamp beyond switch angle");

  property p_no_force;
    @(posedge CLK) disable iff (SYS_RST)
    ANGLE_VALID && (map.falling || (rel[15:6] <= map.thr)) |=> !OUT_FORCED;
  endproperty
  a_no_force: assert property (p_no_force)
    else $error("output forced without cause");

  property p_falling_start;
    @(posedge CLK) disable iff (SYS_RST)
    ANGLE_VALID && map.falling && (rel[15:3] == 13'h0000)
    |=> OUT_CODE == $past(map.upper_clamp_level);
  endproperty
  a_falling_start: assert property (p_falling_start)
    else $error("falling slope does not start at upper clamp");

  property p_out_valid;
    @(posedge CLK) disable iff (SYS_RST)
    ANGLE_VALID |=> OUT_VALID ##1 (OUT_VALID == $past(ANGLE_VALID));
  endproperty
  a_out_valid: assert property (p_out_valid)
    else $error("output valid does not follow angle valid");

  c_forced:  cover property (@(posedge CLK) disable iff (SYS_RST) OUT_VALID && OUT_FORCED);
  c_falling: cover property (@(posedge CLK) disable iff (SYS_RST)
                             ANGLE_VALID && map.falling ##1 OUT_VALID);
  c_read:    cover property (@(posedge CLK) disable iff (SYS_RST)
                             REG_WR ##1 REG_RD ##1 REG_RVALID);

endmodule : amo_angle_map

/* File: testbench/amo_prog_model.sv */
// programmer model that drives the parameter register port
`timescale 1ns/1ps
`include "amo_cfg.svh"

module amo_prog_model
  import amo_pkg::*;
(
  input  wire logic        clk,
  output logic             wr,
  output logic             rd,
  output logic      [3:0]  addr,
  output logic      [15:0] wdata
);
  // idle port at time zero
  initial {wr, rd, addr, wdata} = '0;

  function automatic logic [15:0] legal(input logic [3:0] a, input logic [15:0] d);
    logic [12:0] c;
    c = (d[12:0] < 13'h0100) ? 13'h0100 : ((d[12:0] > 13'h1300) ? 13'h1300 : d[12:0]);
    case (a)
      4'h9:    legal = {d[15:3], 3'h0};
      4'ha:    legal = {3'h0, c};
      4'hb:    legal = {3'h0, c};
      4'hf:    legal = {3'h0, d[12], 2'h3, 1'h0, d[8], d[7:0]};
      default: legal = d;
    endcase
  endfunction : legal

  // one write strobe
  task automatic write_word(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    wr    <= 1'h1;
    addr  <= a;
    wdata <= legal(a, d);
    @(posedge clk);
    wr    <= 1'h0;
    wdata <= ~legal(a, d); // released data no longer valid
  endtask : write_word

  // one read strobe
  task automatic read_word(input logic [3:0] a);
    @(posedge clk);
    rd   <= 1'h1;
    addr <= a;
    @(posedge clk);
    rd   <= 1'h0;
    addr <= ~a;
  endtask : read_word

  // write strobe followed by a read of the same word in the next cycle
  task automatic write_read(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    wr    <= 1'h1;
    addr  <= a;
    wdata <= legal(a, d);
    @(posedge clk);
    wr    <= 1'h0;
    rd    <= 1'h1;
    @(posedge clk);
    rd    <= 1'h0;
    addr  <= ~a;
    wdata <= ~legal(a, d);
  endtask : write_read
endmodule : amo_prog_model

/* File: testbench/amo_angle_map_tb_top.sv */
// self-checking bench of the angle output mapping block
`timescale 1ns/1ps
`include "amo_cfg.svh"

module amo_angle_map_tb_top
  import amo_pkg::*;
;
  logic        clk, sys_rst, wr, rd, rvalid, a_valid, o_valid, forced;
  logic [3:0]  addr;
  logic [15:0] wdata, rdata, ang_in;
  logic [12:0] code;
  logic [15:0] sh [16];
  logic [15:0] rq [$];
  logic [13:0] oq [$];
  int          fail_count, n_tests;

  amo_prog_model p (.clk(clk), .wr(wr), .rd(rd), .addr(addr), .wdata(wdata));

  amo_angle_map dut (.CLK(clk), .SYS_RST(sys_rst), .REG_WR(wr), .REG_RD(rd),
    .REG_ADDR(addr), .REG_WDATA(wdata), .REG_RDATA(rdata), .REG_RVALID(rvalid),
    .ANGLE_VALID(a_valid), .ANGLE(ang_in), .OUT_CODE(code), .OUT_VALID(o_valid),
    .OUT_FORCED(forced));

  // clock at 25 ns
  initial
  begin
    clk = 1'h0;
    forever #12.5 clk = ~clk;
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic end_sim;
    $display("checks %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : end_sim

  function automatic logic mapped(input logic [3:0] a);
    return a inside {4'h7, 4'h9, 4'ha, 4'hb, 4'he, 4'hf};
  endfunction : mapped

  // write, and note mapped words in the shadow copy
  task automatic wrw(input logic [3:0] a, input logic [15:0] d);
    p.write_word(a, d);
    if (mapped(a)) sh[a] = p.legal(a, d);
  endtask : wrw

  // write then read back in the next cycle, noted in the shadow copy
  task automatic wrrd(input logic [3:0] a, input logic [15:0] d);
    sh[a] = p.legal(a, d);
    rq.push_back(sh[a]);
    p.write_read(a, d);
  endtask : wrrd

  // switch angle computed from clamps and multiplier
  function automatic logic [15:0] sw_word(input logic [5:0] mh);
    logic [18:0] m;
    int unsigned t;
    m = {mh, sh[9][15:3]};
    t = (m == 19'h00000) ? 32'h3ff
        : 32'h200 + (32'(sh[11][12:0] - sh[10][12:0]) * 32'h400) / 32'(m);
    return {(t > 32'h3ff) ? 10'h3ff : 10'(t), mh};
  endfunction : sw_word

  task automatic rdw(input logic [3:0] a);
    rq.push_back(mapped(a) ? sh[a] : 16'h0000);
    p.read_word(a);
  endtask : rdw

  function automatic logic [13:0] exp_out(input logic [15:0] a);
    logic [15:0] rel;
    logic [17:0] dl;
    logic [12:0] lo, hi;
    rel = a - sh[7];
    dl = 18'((32'(rel[15:3]) * 32'({sh[14][5:0], sh[9][15:3]})) >> 14);
    lo = sh[10][12:0];
    hi = sh[11][12:0];
    if (sh[15][8]) return {1'h0, (dl > 18'(hi - lo)) ? lo : 13'(hi - dl)};
    if (rel[15:6] > sh[14][15:6]) return {1'h1, lo};
    return {1'h0, ((19'(lo) + dl) > 19'(hi)) ? hi : 13'(lo + dl)};
  endfunction : exp_out

  task automatic ang(input logic [15:0] a);
    @(posedge clk);
    a_valid <= 1'h1;
    ang_in  <= a;
    oq.push_back(exp_out(a));
  endtask : ang

  // result watcher takes the oldest note
  always @(negedge clk)
  begin
    if (rvalid === 1'h1) check(rdata, rq.pop_front());
    if (o_valid === 1'h1) check({2'h0, forced, code}, {2'h0, oq.pop_front()});
  end

  // hang guard
  initial
  begin
    repeat (5000) @(posedge clk);
    fail_count++;
    end_sim();
  end

  // main sequence
  initial
  begin
    {a_valid, ang_in} = '0;
    sys_rst = 1'h1;
    sh[7] = `AMO_RST_ZERO; sh[9] = `AMO_RST_MLOW; sh[10] = `AMO_RST_CLO;
    sh[11] = `AMO_RST_CHI; sh[14] = `AMO_RST_SWMH; sh[15] = `AMO_RST_CUST;
    void'($urandom(90777));
    repeat (20) @(posedge clk);
    sys_rst <= 1'h0;
    foreach (sh[i]) rdw(4'(i));
    $display("test 1 reset values done");
    wrw(4'h7, 16'($urandom));
    wrw(4'h9, 16'($urandom));
    wrw(4'ha, 16'(16'h0100 + $urandom % 16'h06a4));
    wrw(4'hb, 16'(16'h0a28 + $urandom % 16'h08d8));
    wrw(4'he, sw_word(6'($urandom)));
    wrw(4'h3, 16'($urandom));
    foreach (sh[i]) rdw(4'(i));
    wrrd(4'h7, 16'($urandom));
    $display("test 2 write readback done");
    for (int s = 0; s < 2; s++)
    begin
      wrw(4'hf, {7'h0, s[0], 8'h0});
      ang(sh[7]);
      ang(sh[7] + {sh[14][15:6], 6'h3f});
      ang(sh[7] + {sh[14][15:6], 6'h3f} + 16'h0001);
      repeat (40) ang(16'($urandom));
      @(posedge clk);
      a_valid <= 1'h0;
      ang_in  <= ~ang_in;
      repeat (3) @(posedge clk);
      $display("test %0d slope done", s + 3);
    end
    check(16'(rq.size() + oq.size()), 16'h0000);
    end_sim();
  end
endmodule : amo_angle_map_tb_top
